// ===== hdl/sscd_map.vh
// constants for the system clock source and divider configuration block
// assumes one 200 MHz core clock; all slower clocks are enable pulses
`ifndef SSCD_MAP_VH
`define SSCD_MAP_VH

// ----------------------------------------------------------------------
// rates, in MHz
// ----------------------------------------------------------------------
`define SSCD_CLK_MHZ 200
`define SSCD_PLL_VCO_MHZ 400
`define SSCD_PLL_PREDIV 2
`define SSCD_ADC_MHZ 16
`define SSCD_ADC_STEP_UP 8'h10
`define SSCD_ADC_STEP_DOWN 8'hB8

// ----------------------------------------------------------------------
// field widths
// ----------------------------------------------------------------------
`define SSCD_DIV_W 4
`define SSCD_DIV_WIDE_W 6
`define SSCD_OSC_W 2
`define SSCD_CRYSTAL_SELECT_W 5
`define SSCD_PWM_W 3
`define SSCD_PWM_CNT_W 8
`define SSCD_PLLCFG_W 8
`define SSCD_ADC_ACC_W 8

// ----------------------------------------------------------------------
// oscillator source encodings
// ----------------------------------------------------------------------
`define SSCD_OSC_MAIN 2'h0
`define SSCD_OSC_INT 2'h1
`define SSCD_OSC_INT_DIV4 2'h2
`define SSCD_OSC_30K 2'h3
`define SSCD_INT_DIV4_LAST 2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SSCD_RST_DIV 6'h0F
`define SSCD_RST_OSC 2'h1

// ----------------------------------------------------------------------
// pll lock time, in main oscillator periods
// ----------------------------------------------------------------------
`define SSCD_LOCK_SHORT 14'h1200
`define SSCD_LOCK_LONG 14'h2400
`define SSCD_CRYSTAL_SELECT_HIGH 5'h0F
`define SSCD_PLL_XLATE_OFFSET 8'h10

`endif

// ===== hdl/sscd_tick_div.v
// enable-pulse divider: one output pulse every (i_div + 1) input ticks
// assumes i_tick is a one-cycle enable on the same clock
`timescale 1ns/1ps
`default_nettype none

module sscd_tick_div
#(
  parameter W = 6
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_tick,
  input wire [W-1:0] i_div,
  output reg o_pulse
);

  reg [W-1:0] cnt;
  reg [W-1:0] div_hold;

  // ----------------------------------------------------------------------
  // count ticks; a new divisor is taken only at a period boundary
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt <= {W{1'b0}};
      div_hold <= {W{1'b0}};
      o_pulse <= 1'b0;
    end
    else if (i_tick)
    begin
      if (cnt >= div_hold)
      begin
        o_pulse <= 1'b1;
        cnt <= {W{1'b0}};
        div_hold <= i_div;
      end
      else
      begin
        o_pulse <= 1'b0;
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
    else
    begin
      o_pulse <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/sscd_top.v
// system clock source selection, divisors, adc/pwm rates, peripheral gates
// assumes the 200 MHz core clock stands for the halved 400 MHz pll output;
// oscillator ticks arrive from other domains and are synchronised here
//
// Overview of operation
// - extended config fields replace base fields when selected
// - each peripheral gets gated system clock enable
// - converter clock derived automatically at 16 MHz
// - pwm clock synchronously divided from system clock
// - bypass picks pll or oscillator for divisor
// - pll output halved before divisor applied
// - base divisor is encoding plus one
// - wide divisor two bits wider, up to 64
// - wide encoding 0x3F divides by 64
// - extended bypass picks pll or oscillator path
// - no divider and bypassed gives source rate
// - crystal number translated into pll settings
// - deep sleep may override source and divisor
// - source field selects main, int, int/4, 30k
// - stay on oscillator until pll lock expires
`timescale 1ns/1ps
`default_nettype none
`include "sscd_map.vh"

module sscd_top
#(
  parameter N_PERIPH = 8,
  parameter [13:0] LOCK_SHORT = `SSCD_LOCK_SHORT,
  parameter [13:0] LOCK_LONG = `SSCD_LOCK_LONG
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_main_osc_tick,
  input wire i_int_osc_tick,
  input wire i_osc30k_tick,
  input wire i_pll_bypass,
  input wire i_divider_apply,
  input wire [`SSCD_DIV_W-1:0] i_sysclk_divisor_sel,
  input wire [`SSCD_OSC_W-1:0] i_osc_source_sel,
  input wire i_pll_power_down,
  input wire [`SSCD_CRYSTAL_SELECT_W-1:0] i_crystal_select,
  input wire i_pwm_div_use,
  input wire [`SSCD_PWM_W-1:0] i_pwm_clk_divisor,
  input wire i_use_ext_config,
  input wire i_pll_bypass_ext,
  input wire [`SSCD_DIV_WIDE_W-1:0] i_sysclk_divisor_sel_wide,
  input wire [`SSCD_OSC_W-1:0] i_osc_source_sel_ext,
  input wire i_pll_power_down_ext,
  input wire i_deep_sleep,
  input wire i_deep_sleep_override,
  input wire [`SSCD_OSC_W-1:0] i_deep_sleep_osc_sel,
  input wire [`SSCD_DIV_WIDE_W-1:0] i_deep_sleep_div,
  input wire [N_PERIPH-1:0] i_periph_gate,
  output wire o_sysclk_en,
  output reg [N_PERIPH-1:0] o_periph_clk_en,
  output reg o_adc_clk_en,
  output wire o_pwm_clk_en,
  output reg [`SSCD_PLLCFG_W-1:0] o_pll_settings,
  output reg o_pll_locked,
  output reg o_pll_in_use
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3;
  wire [2:0] osc_edge;
  reg [1:0] int_div4_cnt;
  reg int_div4_tick;
  reg [`SSCD_OSC_W-1:0] active_src;
  reg active_pll;
  reg [13:0] lock_cnt;
  reg [`SSCD_CRYSTAL_SELECT_W-1:0] prev_crystal_select;
  reg prev_pwrdn;
  reg [`SSCD_ADC_ACC_W-1:0] adc_acc;
  reg bypass_eff;
  reg pwrdn_eff;
  reg [`SSCD_OSC_W-1:0] src_eff;
  reg [`SSCD_DIV_WIDE_W-1:0] div_eff;
  reg src_tick;
  wire pll_ok;
  wire [`SSCD_DIV_WIDE_W-1:0] next_div;
  wire [`SSCD_PWM_CNT_W-1:0] pwm_div;

  // crystal number to pll setting translation
  function [`SSCD_PLLCFG_W-1:0] crystal_select_to_pll;
    input [`SSCD_CRYSTAL_SELECT_W-1:0] crystal_select;
    begin
      crystal_select_to_pll = {3'h0, crystal_select} + `SSCD_PLL_XLATE_OFFSET;
    end
  endfunction

  // ----------------------------------------------------------------------
  // oscillator tick synchronisers and edge detect
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end
    else
    begin
      sync1 <= {i_osc30k_tick, i_int_osc_tick, i_main_osc_tick};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign osc_edge = sync2 & ~sync3;

  // internal oscillator divided by four
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      int_div4_cnt <= 2'h0;
      int_div4_tick <= 1'b0;
    end
    else
    begin
      int_div4_tick <= osc_edge[1] && (int_div4_cnt == `SSCD_INT_DIV4_LAST);
      if (osc_edge[1])
        int_div4_cnt <= int_div4_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // effective configuration: base, extended or deep-sleep
  // ----------------------------------------------------------------------
  always @*
  begin
    if (i_use_ext_config)
    begin
      bypass_eff = i_pll_bypass_ext;
      pwrdn_eff = i_pll_power_down_ext;
      src_eff = i_osc_source_sel_ext;
      div_eff = i_sysclk_divisor_sel_wide;
    end
    else
    begin
      bypass_eff = i_pll_bypass;
      pwrdn_eff = i_pll_power_down;
      src_eff = i_osc_source_sel;
      div_eff = {2'h0, i_sysclk_divisor_sel};
    end
    if (i_deep_sleep && i_deep_sleep_override)
    begin
      bypass_eff = 1'b1;
      pwrdn_eff = 1'b1;
      src_eff = i_deep_sleep_osc_sel;
      div_eff = i_use_ext_config ? i_deep_sleep_div :
        {2'h0, i_deep_sleep_div[`SSCD_DIV_W-1:0]};
    end
  end

  // pll path only once locked, else keep the oscillator
  assign pll_ok = !bypass_eff && !pwrdn_eff && o_pll_locked;

  // divisor plus one always on pll path; bypass honours divider_apply except under deep-sleep override
  assign next_div = (bypass_eff && !i_divider_apply &&
    !(i_deep_sleep && i_deep_sleep_override)) ?
    {`SSCD_DIV_WIDE_W{1'b0}} : div_eff;

  // ----------------------------------------------------------------------
  // source tick multiplexer from the active (latched) source
  // ----------------------------------------------------------------------
  always @*
  begin
    if (active_pll)
      src_tick = 1'b1;
    else
    begin
      case (active_src)
        `SSCD_OSC_MAIN: src_tick = osc_edge[0];
        `SSCD_OSC_INT: src_tick = osc_edge[1];
        `SSCD_OSC_INT_DIV4: src_tick = int_div4_tick;
        `SSCD_OSC_30K: src_tick = osc_edge[2];
        default: src_tick = 1'b0;
      endcase
    end
  end

  // source switches only at a system clock period boundary
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      active_src <= `SSCD_RST_OSC;
      active_pll <= 1'b0;
      o_pll_in_use <= 1'b0;
    end
    else
    begin
      if (o_sysclk_en)
      begin
        active_src <= src_eff;
        active_pll <= pll_ok;
      end
      o_pll_in_use <= active_pll;
    end
  end

  // ----------------------------------------------------------------------
  // system clock divider
  // ----------------------------------------------------------------------
  sscd_tick_div #(.W(`SSCD_DIV_WIDE_W)) u_sys_div
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(src_tick),
    .i_div(next_div),
    .o_pulse(o_sysclk_en)
  );

  // ----------------------------------------------------------------------
  // pwm divider: 2, 4 ... 256 system clocks, or undivided
  // ----------------------------------------------------------------------
  assign pwm_div = i_pwm_div_use ?
    ((8'h02 << i_pwm_clk_divisor) - 8'h01) : {`SSCD_PWM_CNT_W{1'b0}};

  sscd_tick_div #(.W(`SSCD_PWM_CNT_W)) u_pwm_div
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(o_sysclk_en),
    .i_div(pwm_div),
    .o_pulse(o_pwm_clk_en)
  );

  // ----------------------------------------------------------------------
  // peripheral clock gates
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_PERIPH; g = g + 1)
    begin : gen_gate
      always @(posedge i_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
          o_periph_clk_en[g] <= 1'b0;
        else
          o_periph_clk_en[g] <= i_periph_gate[g] & o_sysclk_en;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // converter clock: fractional accumulator, 16 of every 200 cycles
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      adc_acc <= {`SSCD_ADC_ACC_W{1'b0}};
      o_adc_clk_en <= 1'b0;
    end
    else if (adc_acc >= `SSCD_ADC_STEP_DOWN)
    begin
      adc_acc <= adc_acc - `SSCD_ADC_STEP_DOWN;
      o_adc_clk_en <= 1'b1;
    end
    else
    begin
      adc_acc <= adc_acc + `SSCD_ADC_STEP_UP;
      o_adc_clk_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // pll translation and lock-time counter on main oscillator ticks
  // ----------------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      prev_crystal_select <= {`SSCD_CRYSTAL_SELECT_W{1'b0}};
      prev_pwrdn <= 1'b1;
      lock_cnt <= 14'h0;
      o_pll_locked <= 1'b0;
      o_pll_settings <= {`SSCD_PLLCFG_W{1'b0}};
    end
    else
    begin
      prev_crystal_select <= i_crystal_select;
      prev_pwrdn <= pwrdn_eff;
      o_pll_settings <= crystal_select_to_pll(i_crystal_select);
      if (pwrdn_eff)
      begin
        o_pll_locked <= 1'b0;
        lock_cnt <= 14'h0;
      end
      else if (prev_pwrdn || (prev_crystal_select != i_crystal_select))
      begin
        o_pll_locked <= 1'b0;
        lock_cnt <= (i_crystal_select > `SSCD_CRYSTAL_SELECT_HIGH) ?
          LOCK_LONG : LOCK_SHORT;
      end
      else if (osc_edge[0] && (lock_cnt != 14'h0))
      begin
        lock_cnt <= lock_cnt - 14'h1;
        o_pll_locked <= (lock_cnt == 14'h1);
      end
    end
  end

endmodule
`default_nettype wire

// ===== test/sscd_monitor.sv
// checker for the clock configuration block: rates, gating, pll use
// assumes a bind onto sscd_top with its lock parameters handed on
`timescale 1ns/1ps
`default_nettype none
`include "sscd_map.vh"

module sscd_monitor
#(
  parameter N_PERIPH = 8,
  parameter [13:0] LOCK_SHORT = 14'h4,
  parameter [13:0] LOCK_LONG = 14'h8
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_main_osc_tick,
  input wire logic i_pll_bypass,
  input wire logic i_divider_apply,
  input wire logic [3:0] i_sysclk_divisor_sel,
  input wire logic [1:0] i_osc_source_sel,
  input wire logic i_pll_power_down,
  input wire logic [4:0] i_crystal_select,
  input wire logic i_pwm_div_use,
  input wire logic [2:0] i_pwm_clk_divisor,
  input wire logic i_use_ext_config,
  input wire logic i_pll_bypass_ext,
  input wire logic [5:0] i_sysclk_divisor_sel_wide,
  input wire logic i_pll_power_down_ext,
  input wire logic i_deep_sleep,
  input wire logic i_deep_sleep_override,
  input wire logic [N_PERIPH-1:0] i_periph_gate,
  input wire logic o_sysclk_en,
  input wire logic [N_PERIPH-1:0] o_periph_clk_en,
  input wire logic o_adc_clk_en,
  input wire logic o_pwm_clk_en,
  input wire logic [7:0] o_pll_settings,
  input wire logic o_pll_locked,
  input wire logic o_pll_in_use
);
  // ------------------------------------------------------------------
  // effective controls and period bookkeeping
  // ------------------------------------------------------------------
  wire ds = i_deep_sleep & i_deep_sleep_override;
  wire byp = ds | (i_use_ext_config ? i_pll_bypass_ext : i_pll_bypass);
  wire pd = ds | (i_use_ext_config ? i_pll_power_down_ext : i_pll_power_down);
  wire [21:0] cfg = {ds, byp, pd, i_divider_apply, i_sysclk_divisor_sel,
    i_osc_source_sel, i_pwm_div_use, i_pwm_clk_divisor, i_use_ext_config,
    i_sysclk_divisor_sel_wide, o_pll_in_use};
  reg [1:0] calm;
  reg [8:0] ns;
  reg [6:0] gap;
  reg [6:0] dv;
  reg was_pll;
  reg [7:0] cyc;
  reg [4:0] na;
  reg warm;

  // calm counts pwm pulses, up to 3, since the last change of any field of cfg
  always @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      calm <= 2'h0;
      ns <= 9'h0;
      gap <= 7'h0;
      dv <= 7'h0;
      was_pll <= 1'b0;
      cyc <= 8'h0;
      na <= 5'h0;
      warm <= 1'b0;
    end
    else
    begin
      calm <= $changed(cfg) ? 2'h0 :
        calm + {1'b0, o_pwm_clk_en && calm != 2'h3};
      ns <= o_pwm_clk_en ? 9'h0 : ns + {8'h0, o_sysclk_en};
      gap <= o_sysclk_en ? 7'h1 : gap + 7'h1;
      if (o_sysclk_en)
      begin
        dv <= (i_use_ext_config ? {1'b0, i_sysclk_divisor_sel_wide} :
          {3'h0, i_sysclk_divisor_sel}) + 7'h1;
        was_pll <= o_pll_in_use & ~byp;
      end
      cyc <= (cyc == 8'd199) ? 8'h0 : cyc + 8'h1;
      na <= (cyc == 8'd199) ? 5'h0 : na + {4'h0, o_adc_clk_en};
      warm <= warm | (cyc == 8'd199);
    end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  pll_period_a: assert property (
    o_sysclk_en && was_pll && o_pll_in_use |-> gap == dv)
    else $error("pll period wrong");
  periph_gate_a: assert property (
    o_periph_clk_en == ($past(o_sysclk_en) ? $past(i_periph_gate) : '0))
    else $error("peripheral enable wrong");
  adc_rate_a: assert property (
    warm && cyc == 8'd199 |-> na + {4'h0, o_adc_clk_en} == 5'd16)
    else $error("converter rate wrong");
  pwm_ratio_a: assert property (
    o_pwm_clk_en && calm == 2'h3 |-> ns + {8'h0, o_sysclk_en} ==
    (i_pwm_div_use ? 9'h2 << i_pwm_clk_divisor : 9'h1))
    else $error("pwm ratio wrong");
  pll_pick_a: assert property (
    o_sysclk_en && !byp && !pd && o_pll_locked |-> ##2 o_pll_in_use)
    else $error("pll not taken");
  bypass_kept_a: assert property (
    o_sysclk_en && byp |-> ##2 !o_pll_in_use)
    else $error("pll used while bypassed");
  pll_guard_a: assert property (
    $rose(o_pll_in_use) |-> $past(o_pll_locked))
    else $error("pll used before lock");
  lock_wait_a: assert property (
    $fell(pd) |-> !o_pll_locked [*8])
    else $error("lock came too early");
  crystal_select_map_a: assert property (
    $past(i_reset_n) |-> o_pll_settings ==
    {3'h0, $past(i_crystal_select)} + `SSCD_PLL_XLATE_OFFSET)
    else $error("pll settings wrong");
  undivided_a: assert property (
    calm == 2'h3 && byp && !ds && !i_divider_apply && !i_use_ext_config
    && i_osc_source_sel == 2'h0 && $rose(i_main_osc_tick)
    |-> ##[2:4] o_sysclk_en)
    else $error("source rate not passed");

  pll_run_c: cover property (o_pll_in_use && o_sysclk_en);
  pwm_div_c: cover property (o_pwm_clk_en && i_pwm_div_use);
  sleep_c: cover property (ds && o_sysclk_en);
endmodule

`default_nettype wire

// ===== test/tb.sv
// bench for the clock configuration block: random divisors and gates
// assumes sscd_top and sscd_monitor are compiled before it
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ------------------------------------------------------------------
  // stimulus, checks and sequence
  // ------------------------------------------------------------------
  logic i_clk = 0, i_reset_n = 0, i_main_osc_tick = 0;
  logic i_int_osc_tick = 0, i_osc30k_tick = 0, i_pll_bypass = 1;
  logic i_divider_apply = 0, i_pll_power_down = 1, i_pwm_div_use = 0;
  logic i_use_ext_config = 0, i_pll_bypass_ext = 1;
  logic i_pll_power_down_ext = 1, i_deep_sleep = 0;
  logic i_deep_sleep_override = 0;
  logic [3:0] i_sysclk_divisor_sel = 4'hF;
  logic [1:0] i_osc_source_sel = 2'h1, i_osc_source_sel_ext = 2'h3;
  logic [1:0] i_deep_sleep_osc_sel = 2'h1;
  logic [4:0] i_crystal_select = 5'h0;
  logic [2:0] i_pwm_clk_divisor = 3'h0;
  logic [5:0] i_sysclk_divisor_sel_wide = 6'h0, i_deep_sleep_div = 6'h2;
  logic [7:0] i_periph_gate = 8'hA5;
  wire o_sysclk_en, o_adc_clk_en, o_pwm_clk_en, o_pll_locked, o_pll_in_use;
  wire [7:0] o_periph_clk_en, o_pll_settings;
  integer failures = 0, samples_checked = 0, cyc = 0, n;

  sscd_top #(.LOCK_SHORT(14'h4), .LOCK_LONG(14'h8)) u_sscd_top (.*);

  // core clock, 5 ns period
  initial forever #2.5 i_clk = ~i_clk;

  // oscillator levels of 6, 10 and 14 cycles, plus the run limit
  always @(posedge i_clk)
  begin
    #1;
    cyc = cyc + 1;
    i_main_osc_tick = cyc % 6 < 3;
    i_int_osc_tick = cyc % 10 < 5;
    i_osc30k_tick = cyc % 14 < 7;
    if (cyc == 40000)
    begin
      failures = failures + 1;
      wrap_up;
    end
  end

  task chk(input string what, input [7:0] exp, input [7:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // lets a switch settle, then times one system clock period
  task per(input [7:0] exp);
  begin
    repeat (4) do @(posedge i_clk); while (o_sysclk_en !== 1'b1);
    n = 0;
    do
    begin
      @(posedge i_clk);
      n = n + 1;
    end
    while (o_sysclk_en !== 1'b1);
    chk("sysclk period", exp, n[7:0]);
  end
  endtask

  // expected pll settings for a crystal number
  function automatic [7:0] crystal_select_exp(input [4:0] x);
    return {3'h0, x} + 8'h10;
  endfunction

  task wrap_up;
  begin
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  // main sequence: sources, divisors, deep sleep, pll, wide field
  initial
  begin
    void'($urandom(32'h27b6));
    repeat (8) @(posedge i_clk);
    #1 i_reset_n = 1;
    @(posedge i_clk);
    for (int s = 0; s < 4; s++)
    begin
      #1 i_osc_source_sel = s[1:0];
      per(s == 0 ? 6 : s == 1 ? 10 : s == 2 ? 40 : 14);
    end
    #1 i_osc_source_sel = 2'h0;
    i_divider_apply = 1;
    i_sysclk_divisor_sel = 4'($urandom);
    per(6 * (i_sysclk_divisor_sel + 1));
    #1 i_deep_sleep = 1;
    i_deep_sleep_override = 1;
    per(30);
    #1 i_deep_sleep = 0;
    i_crystal_select = 5'($urandom) | 5'h10;
    repeat (3) @(posedge i_clk);
    chk("pll settings", crystal_select_exp(i_crystal_select), o_pll_settings);
    #1 i_pll_power_down = 0;
    i_pll_power_down_ext = 0;
    repeat (100) @(posedge i_clk);
    chk("pll locked", 8'h1, {7'h0, o_pll_locked});
    repeat (4)
    begin
      #1 i_sysclk_divisor_sel = 4'($urandom_range(11, 3));
      i_pll_bypass = 0;
      i_pwm_div_use = 1;
      i_pwm_clk_divisor = 3'($urandom_range(2, 0));
      i_periph_gate = 8'($urandom);
      per(i_sysclk_divisor_sel + 1);
      repeat (600) @(posedge i_clk);
    end
    #1 i_use_ext_config = 1;
    i_pll_bypass_ext = 0;
    i_sysclk_divisor_sel_wide = 6'h3F;
    per(64);
    #1 i_pll_bypass_ext = 1;
    i_sysclk_divisor_sel_wide = 6'($urandom_range(3, 0));
    per(14 * (i_sysclk_divisor_sel_wide + 1));
    wrap_up;
  end
endmodule

bind sscd_top sscd_monitor #(.N_PERIPH(N_PERIPH), .LOCK_SHORT(LOCK_SHORT),
  .LOCK_LONG(LOCK_LONG)) u_sscd_monitor (.*);

`default_nettype wire
